/* File: rtl/ieig_regs.svh */
/*
 * Register indices, reset values and field positions of the inertial
 * event interrupt generator.
 * Assumes an APB slave decoding paddr[7:2] as the register index.
 */
`ifndef IEIG_REGS_SVH
`define IEIG_REGS_SVH

// register indices (byte address is four times the index)
`define IEIG_IDX_CFG1 6'h30
`define IEIG_IDX_SRC1 6'h31
`define IEIG_IDX_THS1 6'h32
`define IEIG_IDX_DUR1 6'h33
`define IEIG_IDX_CFG2 6'h34
`define IEIG_IDX_SRC2 6'h35
`define IEIG_IDX_THS2 6'h36
`define IEIG_IDX_DUR2 6'h37
`define IEIG_IDX_CTRL 6'h38
`define IEIG_IDX_STAT 6'h39
`define IEIG_IDX_MASK 6'h3a

// reset values and constants
`define IEIG_RST_BYTE 8'h00
`define IEIG_RST_FIELD 7'h00
`define IEIG_RST_PAIR 2'h0
`define IEIG_ZERO7 7'h00
`define IEIG_NO_HITS 6'h00
`define IEIG_DUR_MAX 7'h7f
`define IEIG_PAD24 24'h000000

// field positions
`define IEIG_AND_BIT 7
`define IEIG_SIXD_BIT 6
`define IEIG_ACT_BIT 6

`endif

/* File: rtl/ieig_pkg.sv */
/*
 * Types shared by the inertial event interrupt generator.
 * Assumes nothing of its surroundings.
 */
package ieig_pkg;
	// combine mode from {and select, six direction enable}
	typedef enum logic [1:0] {mode_or, mode_move, mode_and, mode_pos} ieig_mode_t;
endpackage : ieig_pkg

/* File: rtl/ieig_dur_counter.sv */
/*
 * Minimum duration counter of one event generator.
 * Assumes sample_valid pulses once per output sample, same clock.
 */
`timescale 1ns/1ns
`include "ieig_regs.svh"
module ieig_dur_counter
	import ieig_pkg::*;
(
	// clock and reset
	input logic core_clk,
	input logic reset,
	// condition per sample
	input logic sample_valid,
	input logic hit,
	input logic [6:0] duration_value,
	// result
	output logic reached
);
	logic [6:0] count_reg;

	// counts consecutive hit samples, saturating, cleared by a miss
	always_ff @(posedge core_clk) begin
		if (reset) begin
			count_reg <= `IEIG_RST_FIELD;
		end else if (sample_valid) begin
			if (!hit) begin
				count_reg <= `IEIG_RST_FIELD;
			end else if (count_reg != `IEIG_DUR_MAX) begin
				count_reg <= 7'(count_reg + 7'h01);
			end
		end
	end

	// enough earlier consecutive samples seen
	assign reached = (count_reg >= duration_value);

	a_count_per_sample: assert property (@(posedge core_clk) disable iff (reset)
		!sample_valid |=> $stable(count_reg))
		else $error("duration count moved without a sample");
endmodule : ieig_dur_counter

/* File: rtl/ieig_event_gen.sv */
/*
 * One inertial event generator: per-axis compare, mode combine,
 * duration check and the source register with its latch option.
 * Assumes samples are 6-bit two's complement on the core clock.
 */
`timescale 1ns/1ns
`include "ieig_regs.svh"
module ieig_event_gen
	import ieig_pkg::*;
(
	// clock and reset
	input logic core_clk,
	input logic reset,
	// samples, {z, y, x}
	input logic sample_valid,
	input logic [17:0] sample_xyz,
	// settings
	input logic [7:0] config_byte,
	input logic [6:0] threshold_value,
	input logic [6:0] duration_value,
	input logic latch_enable,
	input logic source_read,
	// results
	output logic [6:0] source_bits,
	output logic event_set,
	output logic event_pin
);
	logic [5:0] over_under; // {zh, zl, yh, yl, xh, xl}
	logic [5:0] enabled;
	logic [5:0] hits;
	logic [5:0] prev_hits_reg;
	logic [5:0] flags_reg;
	logic active_reg;
	logic six_d;
	logic hit;
	logic dur_reached;
	logic frozen;
	logic recognized;
	ieig_mode_t mode;

	assign enabled = config_byte[5:0];
	assign six_d = config_byte[`IEIG_SIXD_BIT];
	assign mode = ieig_mode_t'({config_byte[`IEIG_AND_BIT], six_d});

	// per-axis compare of magnitude, or of signed side in six direction modes
	for (genvar i = 0; i < 3; i++) begin : g_axis
		logic [6:0] ext;
		logic [6:0] mag;
		assign ext = {sample_xyz[6*i+5], sample_xyz[6*i +: 6]};
		assign mag = ext[6] ? 7'(`IEIG_ZERO7 - ext) : ext;
		assign over_under[2*i+1] = (mag > threshold_value) && !(six_d && ext[6]);
		assign over_under[2*i] = six_d ? (ext[6] && (mag > threshold_value))
			: (mag < threshold_value);
	end

	assign hits = over_under & enabled;

	// combine enabled events as the mode says
	always_comb begin
		unique case (mode)
			mode_or: hit = |hits;
			mode_and: hit = (enabled != `IEIG_NO_HITS) && (&(over_under | ~enabled));
			mode_move: hit = (hits != `IEIG_NO_HITS) && (hits != prev_hits_reg);
			mode_pos: hit = |hits;
		endcase
	end

	ieig_dur_counter u_dur (
		.core_clk(core_clk),
		.reset(reset),
		.sample_valid(sample_valid),
		.hit(hit),
		.duration_value(duration_value),
		.reached(dur_reached)
	);

	assign frozen = latch_enable && active_reg;
	assign recognized = sample_valid && hit && dur_reached;
	assign event_set = recognized && !frozen;

	// previous direction pattern for movement recognition
	always_ff @(posedge core_clk) begin
		if (reset) begin
			prev_hits_reg <= `IEIG_NO_HITS;
		end else if (sample_valid) begin
			prev_hits_reg <= hits;
		end
	end

	// per-axis flags refresh each sample unless frozen by the latch
	always_ff @(posedge core_clk) begin
		if (reset) begin
			flags_reg <= `IEIG_NO_HITS;
		end else if (sample_valid && !frozen) begin
			flags_reg <= recognized ? hits : `IEIG_NO_HITS;
		end
	end

	// active flag: set wins over the clearing read
	always_ff @(posedge core_clk) begin
		if (reset) begin
			active_reg <= 1'b0;
		end else if (event_set) begin
			active_reg <= 1'b1;
		end else if (source_read) begin
			active_reg <= 1'b0;
		end
	end

	assign source_bits = {active_reg, flags_reg};
	assign event_pin = active_reg;

	a_latch_hold: assert property (@(posedge core_clk) disable iff (reset)
		(latch_enable && active_reg && !source_read) |=> $stable(flags_reg))
		else $error("latched source changed before read");
	a_active_cause: assert property (@(posedge core_clk) disable iff (reset)
		$rose(active_reg) |-> $past(sample_valid && hit && dur_reached))
		else $error("active set without a full duration");
	a_disabled_flags: assert property (@(posedge core_clk) disable iff (reset)
		(sample_valid && !frozen) |=> ((flags_reg & ~$past(enabled)) == `IEIG_NO_HITS))
		else $error("flag set for a disabled event");
	a_and_mode: assert property (@(posedge core_clk) disable iff (reset)
		(mode == mode_and && ((hits ^ enabled) != `IEIG_NO_HITS)) |-> !hit)
		else $error("and mode hit with an event missing");
endmodule : ieig_event_gen

/* File: rtl/ieig_top.sv */
/*
 * Inertial event interrupt generator: two event generators, their
 * register file on APB, two event pins and one summary interrupt.
 * Assumes samples and the APB master share core_clk.
 */
// Implementation choice: the APB slave port.
`timescale 1ns/1ns
`include "ieig_regs.svh"
// Notes on behaviour
// - active flag set on any generated event
// - six axis flags set by their events
// - reading source one clears active and pin
// - reading source two clears active and pin
// - latched source frozen until read
// - source registers ignore writes
// - seven bit threshold, reset zero
// - seven bit duration, reset zero
// - duration counted in sample periods
// - over enable requests above threshold
// - under enable requests below threshold, or negative beyond it in six direction modes
// - mode bits select or, and, six direction
// - second config bits reset to or
// - first config register alike, resets zero
module ieig_top
	import ieig_pkg::*;
(
	// clock and reset
	input logic core_clk,
	input logic reset,
	// apb slave
	input logic psel,
	input logic penable,
	input logic pwrite,
	input logic [7:0] paddr,
	input logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// acceleration samples
	input logic sample_valid,
	input logic [5:0] x_sample,
	input logic [5:0] y_sample,
	input logic [5:0] z_sample,
	// event pins and interrupt
	output logic event1_pin,
	output logic event2_pin,
	output logic irq
);
	logic [7:0] cfg1_reg;
	logic [6:0] ths1_reg;
	logic [6:0] dur1_reg;
	logic [7:0] cfg2_reg;
	logic [6:0] ths2_reg;
	logic [6:0] dur2_reg;
	logic [1:0] latch_reg;
	logic [1:0] irq_stat_reg;
	logic [1:0] irq_mask_reg;
	logic [1:0] irq_stat_next;
	logic [31:0] prdata_reg;
	logic pready_reg;
	logic pslverr_reg;
	logic irq_reg;
	logic [5:0] idx;
	logic access;
	logic capture;
	logic wr_done;
	logic mapped;
	logic [7:0] rd_byte;
	logic src1_read;
	logic src2_read;
	logic [6:0] src1;
	logic [6:0] src2;
	logic set1;
	logic set2;
	logic pin1;
	logic pin2;
	logic [17:0] sample_xyz;

	assign sample_xyz = {z_sample, y_sample, x_sample};

	// apb phases: one wait cycle, read data and read side effects at capture, writes land at completion
	assign idx = paddr[7:2];
	assign access = psel && penable;
	assign capture = access && !pready_reg;
	assign wr_done = access && pready_reg && pwrite;

	// source reads clear the active flag at the capture edge
	assign src1_read = capture && !pwrite && (idx == `IEIG_IDX_SRC1);
	assign src2_read = capture && !pwrite && (idx == `IEIG_IDX_SRC2);

	ieig_event_gen u_gen1 (
		.core_clk(core_clk),
		.reset(reset),
		.sample_valid(sample_valid),
		.sample_xyz(sample_xyz),
		.config_byte(cfg1_reg),
		.threshold_value(ths1_reg),
		.duration_value(dur1_reg),
		.latch_enable(latch_reg[0]),
		.source_read(src1_read),
		.source_bits(src1),
		.event_set(set1),
		.event_pin(pin1)
	);

	ieig_event_gen u_gen2 (
		.core_clk(core_clk),
		.reset(reset),
		.sample_valid(sample_valid),
		.sample_xyz(sample_xyz),
		.config_byte(cfg2_reg),
		.threshold_value(ths2_reg),
		.duration_value(dur2_reg),
		.latch_enable(latch_reg[1]),
		.source_read(src2_read),
		.source_bits(src2),
		.event_set(set2),
		.event_pin(pin2)
	);

	// address decode and read mux, reserved bits read zero
	always_comb begin
		mapped = 1'b1;
		rd_byte = `IEIG_RST_BYTE;
		unique case (idx)
			`IEIG_IDX_CFG1: rd_byte = cfg1_reg;
			`IEIG_IDX_SRC1: rd_byte = {1'b0, src1};
			`IEIG_IDX_THS1: rd_byte = {1'b0, ths1_reg};
			`IEIG_IDX_DUR1: rd_byte = {1'b0, dur1_reg};
			`IEIG_IDX_CFG2: rd_byte = cfg2_reg;
			`IEIG_IDX_SRC2: rd_byte = {1'b0, src2};
			`IEIG_IDX_THS2: rd_byte = {1'b0, ths2_reg};
			`IEIG_IDX_DUR2: rd_byte = {1'b0, dur2_reg};
			`IEIG_IDX_CTRL: rd_byte = {6'h00, latch_reg};
			`IEIG_IDX_STAT: rd_byte = {6'h00, irq_stat_reg};
			`IEIG_IDX_MASK: rd_byte = {6'h00, irq_mask_reg};
			default: mapped = 1'b0;
		endcase
	end

	// apb answer flops
	always_ff @(posedge core_clk) begin
		if (reset) begin
			pready_reg <= 1'b0;
			pslverr_reg <= 1'b0;
			prdata_reg <= {`IEIG_PAD24, `IEIG_RST_BYTE};
		end else begin
			pready_reg <= capture;
			pslverr_reg <= capture && !mapped;
			if (capture && !pwrite) begin
				prdata_reg <= {`IEIG_PAD24, rd_byte};
			end
		end
	end

	// first generator settings
	always_ff @(posedge core_clk) begin
		if (reset) begin
			cfg1_reg <= `IEIG_RST_BYTE;
			ths1_reg <= `IEIG_RST_FIELD;
			dur1_reg <= `IEIG_RST_FIELD;
		end else if (wr_done) begin
			if (idx == `IEIG_IDX_CFG1) begin
				cfg1_reg <= pwdata[7:0];
			end
			if (idx == `IEIG_IDX_THS1) begin
				ths1_reg <= pwdata[6:0];
			end
			if (idx == `IEIG_IDX_DUR1) begin
				dur1_reg <= pwdata[6:0];
			end
		end
	end

	// second generator settings; source indices have no write path
	always_ff @(posedge core_clk) begin
		if (reset) begin
			cfg2_reg <= `IEIG_RST_BYTE;
			ths2_reg <= `IEIG_RST_FIELD;
			dur2_reg <= `IEIG_RST_FIELD;
		end else if (wr_done) begin
			if (idx == `IEIG_IDX_CFG2) begin
				cfg2_reg <= pwdata[7:0];
			end
			if (idx == `IEIG_IDX_THS2) begin
				ths2_reg <= pwdata[6:0];
			end
			if (idx == `IEIG_IDX_DUR2) begin
				dur2_reg <= pwdata[6:0];
			end
		end
	end

	// latch option and interrupt mask
	always_ff @(posedge core_clk) begin
		if (reset) begin
			latch_reg <= `IEIG_RST_PAIR;
			irq_mask_reg <= `IEIG_RST_PAIR;
		end else if (wr_done) begin
			if (idx == `IEIG_IDX_CTRL) begin
				latch_reg <= pwdata[1:0];
			end
			if (idx == `IEIG_IDX_MASK) begin
				irq_mask_reg <= pwdata[1:0];
			end
		end
	end

	// sticky status, write one to clear, a new event wins
	always_comb begin
		irq_stat_next = irq_stat_reg;
		if (wr_done && (idx == `IEIG_IDX_STAT)) begin
			irq_stat_next = irq_stat_reg & ~pwdata[1:0];
		end
		irq_stat_next = irq_stat_next | {set2, set1};
	end

	always_ff @(posedge core_clk) begin
		if (reset) begin
			irq_stat_reg <= `IEIG_RST_PAIR;
		end else begin
			irq_stat_reg <= irq_stat_next;
		end
	end

	// registered outputs
	always_ff @(posedge core_clk) begin
		if (reset) begin
			irq_reg <= 1'b0;
			event1_pin <= 1'b0;
			event2_pin <= 1'b0;
		end else begin
			irq_reg <= |(irq_stat_reg & irq_mask_reg);
			event1_pin <= pin1;
			event2_pin <= pin2;
		end
	end

	assign prdata = prdata_reg;
	assign pready = pready_reg;
	assign pslverr = pslverr_reg;
	assign irq = irq_reg;

	a_src1_clear: assert property (@(posedge core_clk) disable iff (reset)
		(src1_read && !set1) |=> ##1 !event1_pin)
		else $error("source one read did not clear pin one");
	a_src2_clear: assert property (@(posedge core_clk) disable iff (reset)
		(src2_read && !set2) |=> (!src2[6] ##1 !event2_pin))
		else $error("source two read did not clear active");
	a_src_readonly: assert property (@(posedge core_clk) disable iff (reset)
		(wr_done && idx == `IEIG_IDX_SRC1 && !sample_valid) |=> $stable(src1))
		else $error("write changed source one");
	a_ths_reset: assert property (@(posedge core_clk)
		reset |=> (ths1_reg == `IEIG_RST_FIELD && ths2_reg == `IEIG_RST_FIELD))
		else $error("threshold not zero after reset");
	a_dur_reset: assert property (@(posedge core_clk)
		reset |=> (dur1_reg == `IEIG_RST_FIELD && dur2_reg == `IEIG_RST_FIELD))
		else $error("duration not zero after reset");
	a_cfg_reset: assert property (@(posedge core_clk)
		reset |=> (cfg2_reg == `IEIG_RST_BYTE && cfg1_reg == `IEIG_RST_BYTE))
		else $error("config not zero after reset");
	a_active_reset: assert property (@(posedge core_clk)
		reset |=> (!src1[`IEIG_ACT_BIT] && src2 == `IEIG_RST_FIELD))
		else $error("source not clear after reset");
	a_bit7_zero: assert property (@(posedge core_clk) disable iff (reset)
		(capture && !pwrite && idx == `IEIG_IDX_THS1) |=> (pready && !prdata[7]))
		else $error("threshold bit seven read nonzero");
	a_irq_level: assert property (@(posedge core_clk) disable iff (reset)
		(|(irq_stat_reg & irq_mask_reg)) |=> irq)
		else $error("interrupt low with unmasked status");

	// apb answer: one cycle wide, error only with ready, upper data bits zero
	a_ready_pulse: assert property (@(posedge core_clk) disable iff (reset)
		pready |=> !pready)
		else $error("ready stood longer than one cycle");
	a_ready_follow: assert property (@(posedge core_clk) disable iff (reset)
		capture |=> pready)
		else $error("no ready after capture");
	a_err_with_ready: assert property (@(posedge core_clk) disable iff (reset)
		pslverr |-> pready)
		else $error("error without ready");
	a_rdata_upper: assert property (@(posedge core_clk) disable iff (reset)
		pready |-> (prdata[31:8] == `IEIG_PAD24))
		else $error("read data upper bits nonzero");
	a_unmapped_err: assert property (@(posedge core_clk) disable iff (reset)
		(capture && !mapped) |=> (pready && pslverr))
		else $error("unmapped index answered without error");
	a_mapped_ok: assert property (@(posedge core_clk) disable iff (reset)
		(capture && mapped) |=> !pslverr)
		else $error("mapped index answered with error");

	// source reads return the flags with bit seven clear, writes leave them
	a_src1_data: assert property (@(posedge core_clk) disable iff (reset)
		src1_read |=> (prdata == {`IEIG_PAD24, 1'b0, $past(src1)}))
		else $error("source one read data wrong");
	a_src2_data: assert property (@(posedge core_clk) disable iff (reset)
		src2_read |=> (prdata == {`IEIG_PAD24, 1'b0, $past(src2)}))
		else $error("source two read data wrong");
	a_src2_readonly: assert property (@(posedge core_clk) disable iff (reset)
		(wr_done && idx == `IEIG_IDX_SRC2 && !sample_valid) |=> $stable(src2))
		else $error("write changed source two");

	// setting writes land at the completing edge
	a_ths1_write: assert property (@(posedge core_clk) disable iff (reset)
		(wr_done && idx == `IEIG_IDX_THS1) |=> (ths1_reg == $past(pwdata[6:0])))
		else $error("threshold one write lost");
	a_ths2_write: assert property (@(posedge core_clk) disable iff (reset)
		(wr_done && idx == `IEIG_IDX_THS2) |=> (ths2_reg == $past(pwdata[6:0])))
		else $error("threshold two write lost");
	a_dur1_write: assert property (@(posedge core_clk) disable iff (reset)
		(wr_done && idx == `IEIG_IDX_DUR1) |=> (dur1_reg == $past(pwdata[6:0])))
		else $error("duration one write lost");
	a_dur2_write: assert property (@(posedge core_clk) disable iff (reset)
		(wr_done && idx == `IEIG_IDX_DUR2) |=> (dur2_reg == $past(pwdata[6:0])))
		else $error("duration two write lost");
	a_cfg1_write: assert property (@(posedge core_clk) disable iff (reset)
		(wr_done && idx == `IEIG_IDX_CFG1) |=> (cfg1_reg == $past(pwdata[7:0])))
		else $error("config one write lost");
	a_cfg2_write: assert property (@(posedge core_clk) disable iff (reset)
		(wr_done && idx == `IEIG_IDX_CFG2) |=> (cfg2_reg == $past(pwdata[7:0])))
		else $error("config two write lost");

	// event pins follow the active flags one cycle later
	a_pin1_high: assert property (@(posedge core_clk) disable iff (reset)
		src1[`IEIG_ACT_BIT] |=> event1_pin)
		else $error("pin one low while active");
	a_pin1_low: assert property (@(posedge core_clk) disable iff (reset)
		!src1[`IEIG_ACT_BIT] |=> !event1_pin)
		else $error("pin one high while inactive");
	a_pin2_high: assert property (@(posedge core_clk) disable iff (reset)
		src2[`IEIG_ACT_BIT] |=> event2_pin)
		else $error("pin two low while active");
	a_pin2_low: assert property (@(posedge core_clk) disable iff (reset)
		!src2[`IEIG_ACT_BIT] |=> !event2_pin)
		else $error("pin two high while inactive");

	// sticky status and the level interrupt
	a_stat_set1: assert property (@(posedge core_clk) disable iff (reset)
		set1 |=> irq_stat_reg[0])
		else $error("status one not set by event");
	a_stat_set2: assert property (@(posedge core_clk) disable iff (reset)
		set2 |=> irq_stat_reg[1])
		else $error("status two not set by event");
	a_stat_clear: assert property (@(posedge core_clk) disable iff (reset)
		(wr_done && idx == `IEIG_IDX_STAT && pwdata[0] && !set1) |=> !irq_stat_reg[0])
		else $error("status one not cleared by write");
	a_irq_masked: assert property (@(posedge core_clk) disable iff (reset)
		!(|(irq_stat_reg & irq_mask_reg)) |=> !irq)
		else $error("interrupt high with nothing unmasked");
endmodule : ieig_top

/* File: verif/ieig_host_model.sv */
/*
 * Host model: an APB master that performs single register transfers.
 * Assumes the block answers with pready on core_clk.
 */
`timescale 1ns/1ns
module ieig_host_model (
	// clock
	input wire logic core_clk,
	// apb request
	output logic psel,
	output logic penable,
	output logic pwrite,
	output logic [7:0] paddr,
	output logic [31:0] pwdata,
	// apb answer
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr
);
	// idle bus at time zero
	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h00000000;
	end

	// one transfer; the request stands until pready is seen high
	task automatic xfer(input logic wr, input logic [5:0] idx, input logic [7:0] wd,
			output logic [7:0] rd, output logic err);
		@(posedge core_clk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= {idx, 2'b00};
		pwdata <= {24'h000000, wd};
		@(posedge core_clk);
		penable <= 1'b1;
		// no limit here: only the bench watchdog ends a wait
		do begin
			@(posedge core_clk);
		end while (pready !== 1'b1);
		rd = prdata[7:0];
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		// released lines show a changing pattern, not the last value
		paddr <= ~paddr;
		pwdata <= ~pwdata;
	endtask : xfer
endmodule : ieig_host_model

/* File: verif/tb.sv */
/*
 * Self-checking bench of the event interrupt generator.
 * Assumes the host model drives APB and the bench drives samples.
 */
`timescale 1ns/1ns
module tb;
	logic core_clk, reset, psel, penable, pwrite, pready, pslverr, sample_valid;
	logic event1_pin, event2_pin, irq, er;
	logic [7:0] paddr, rd;
	logic [31:0] pwdata, prdata;
	logic [5:0] x_sample, y_sample, z_sample;
	int err_total, samples_checked;

	// design and host
	ieig_top ieig_top_i (.core_clk(core_clk), .reset(reset), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.sample_valid(sample_valid), .x_sample(x_sample), .y_sample(y_sample),
		.z_sample(z_sample), .event1_pin(event1_pin), .event2_pin(event2_pin),
		.irq(irq));
	ieig_host_model ieig_host_model_i (.core_clk(core_clk), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr));

	// 100 MHz clock
	always #5 core_clk = ~core_clk;

	task automatic report_and_stop;
		if (err_total == 0 && samples_checked > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : report_and_stop

	task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string m);
		samples_checked++;
		if (got !== exp) begin
			err_total++;
			$display("MISMATCH %0t %s got %h exp %h", $time, m, got, exp);
		end
	endtask : chk

	task automatic wr(input logic [5:0] idx, input logic [7:0] d);
		ieig_host_model_i.xfer(1'b1, idx, d, rd, er);
	endtask : wr

	task automatic rdc(input logic [5:0] idx, input logic [7:0] exp, input string m);
		ieig_host_model_i.xfer(1'b0, idx, 8'h00, rd, er);
		chk(rd, exp, m);
	endtask : rdc

	// one sample pulse, then settle so pins have followed
	task automatic smp(input logic [5:0] x, input logic [5:0] y);
		@(posedge core_clk);
		sample_valid <= 1'b1;
		x_sample <= x;
		y_sample <= y;
		z_sample <= 6'h00;
		@(posedge core_clk);
		sample_valid <= 1'b0;
		x_sample <= ~x;
		y_sample <= ~y;
		z_sample <= 6'h3f;
		repeat (2) @(posedge core_clk);
	endtask : smp

	task automatic t_reset;
		for (int i = 0; i < 8; i++) begin
			rdc(6'h30 + i[5:0], 8'h00, "reset value");
		end
		chk({6'h00, event1_pin, event2_pin}, 8'h00, "pins after reset");
	endtask : t_reset

	task automatic t_regs;
		wr(6'h32, 8'hff);
		rdc(6'h32, 8'h7f, "threshold width");
		wr(6'h33, 8'hff);
		rdc(6'h33, 8'h7f, "duration width");
		wr(6'h30, 8'hff);
		rdc(6'h30, 8'hff, "config one");
		wr(6'h34, 8'hc0);
		rdc(6'h34, 8'hc0, "config two");
		wr(6'h31, 8'hff);
		rdc(6'h31, 8'h00, "source one write");
		wr(6'h35, 8'hff);
		rdc(6'h35, 8'h00, "source two write");
		rdc(6'h10, 8'h00, "unmapped read");
		chk({7'h00, er}, 8'h01, "unmapped error");
		wr(6'h30, 8'h00);
		wr(6'h34, 8'h00);
	endtask : t_regs

	task automatic t_dur;
		wr(6'h32, 8'h05);
		wr(6'h33, 8'h02);
		wr(6'h30, 8'h02);
		smp(6'h0a, 6'h00);
		smp(6'h0a, 6'h00);
		rdc(6'h31, 8'h00, "early event");
		smp(6'h0a, 6'h00);
		chk({7'h00, event1_pin}, 8'h01, "pin one set");
		rdc(6'h31, 8'h42, "over event");
		repeat (2) @(posedge core_clk);
		chk({7'h00, event1_pin}, 8'h00, "pin one cleared");
	endtask : t_dur

	task automatic t_under;
		wr(6'h36, 8'h05);
		wr(6'h34, 8'h01);
		smp(6'h02, 6'h00);
		chk({7'h00, event2_pin}, 8'h01, "pin two set");
		rdc(6'h35, 8'h41, "under event");
		repeat (2) @(posedge core_clk);
		chk({7'h00, event2_pin}, 8'h00, "pin two cleared");
	endtask : t_under

	task automatic t_modes;
		wr(6'h33, 8'h00);
		wr(6'h30, 8'h8a);
		smp(6'h0a, 6'h00);
		rdc(6'h31, 8'h00, "and partial");
		smp(6'h0a, 6'h0a);
		rdc(6'h31, 8'h4a, "and full");
		wr(6'h30, 8'hc2);
		smp(6'h0a, 6'h00);
		rdc(6'h31, 8'h42, "position");
		wr(6'h30, 8'hc1);
		smp(6'h36, 6'h00);
		rdc(6'h31, 8'h41, "position negative");
		smp(6'h02, 6'h00);
		rdc(6'h31, 8'h00, "position positive under");
		wr(6'h30, 8'h42);
		smp(6'h00, 6'h00);
		smp(6'h0a, 6'h00);
		rdc(6'h31, 8'h42, "movement");
		smp(6'h0a, 6'h00);
		rdc(6'h31, 8'h00, "no movement");
	endtask : t_modes

	task automatic t_latch;
		wr(6'h38, 8'h01);
		wr(6'h30, 8'h03);
		smp(6'h0a, 6'h00);
		smp(6'h01, 6'h00);
		rdc(6'h31, 8'h42, "latched frozen");
		smp(6'h01, 6'h00);
		rdc(6'h31, 8'h41, "latched refresh");
		wr(6'h38, 8'h00);
	endtask : t_latch

	task automatic t_irq;
		wr(6'h39, 8'h03);
		rdc(6'h39, 8'h00, "status cleared");
		wr(6'h3a, 8'h01);
		wr(6'h30, 8'h02);
		smp(6'h0a, 6'h00);
		chk({7'h00, irq}, 8'h01, "irq raised");
		rdc(6'h39, 8'h01, "status set");
		wr(6'h3a, 8'h00);
		repeat (2) @(posedge core_clk);
		chk({7'h00, irq}, 8'h00, "irq masked");
		wr(6'h3a, 8'h01);
		repeat (2) @(posedge core_clk);
		chk({7'h00, irq}, 8'h01, "irq unmasked");
		wr(6'h39, 8'h01);
		repeat (2) @(posedge core_clk);
		chk({7'h00, irq}, 8'h00, "irq cleared");
		rdc(6'h31, 8'h42, "source after irq");
	endtask : t_irq

	// main sequence
	initial begin
		core_clk = 1'b0;
		reset = 1'b1;
		sample_valid = 1'b0;
		x_sample = 6'h00;
		y_sample = 6'h00;
		z_sample = 6'h00;
		err_total = 0;
		samples_checked = 0;
		repeat (20) @(posedge core_clk);
		reset <= 1'b0;
		t_reset();
		t_regs();
		t_dur();
		t_under();
		t_modes();
		t_latch();
		t_irq();
		report_and_stop();
	end

	// watchdog against a hung handshake
	initial begin
		#200000;
		err_total++;
		report_and_stop();
	end
endmodule : tb
